/* File: core/idci_pkg.sv */
// Constants, field layouts and types shared by the isolated DIO core.
// Assumes one 10 MHz clock and a plain strobe-based register port.
`default_nettype none

package idci_pkg;

	// Timing
	localparam int CLOCK_HZ           = 10_000_000;
	localparam int FREQ_WINDOW_US     = 1000;
	localparam int FREQ_WINDOW_CYCLES =
		FREQ_WINDOW_US * (CLOCK_HZ / 1_000_000);

	// Line counts and counter wiring
	localparam int NUM_IN  = 16;
	localparam int NUM_OUT = 8;
	localparam int NUM_CTR = 2;
	localparam int CTR0_COUNT_LINE = 0;
	localparam int CTR0_GATE_LINE  = 2;
	localparam int CTR1_COUNT_LINE = 4;
	localparam int CTR1_GATE_LINE  = 6;

	// Register byte offsets
	localparam logic [7:0] OFS_INPUT    = 8'h00;
	localparam logic [7:0] OFS_OUTPUT   = 8'h04;
	localparam logic [7:0] OFS_BOARD_ID = 8'h08;
	localparam logic [7:0] OFS_PAT_MASK = 8'h0C;
	localparam logic [7:0] OFS_PAT_VAL  = 8'h10;
	localparam logic [7:0] OFS_COS_MASK = 8'h14;
	localparam logic [7:0] OFS_EDGE_EN  = 8'h18;
	localparam logic [7:0] OFS_EDGE_POL = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	localparam logic [7:0] OFS_CTR_BASE = 8'h30;
	localparam logic [7:0] CTR_STRIDE   = 8'h10;
	localparam logic [7:0] CTR_CTRL     = 8'h00;
	localparam logic [7:0] CTR_MATCH    = 8'h04;
	localparam logic [7:0] CTR_VALUE    = 8'h08;
	localparam logic [7:0] CTR_PERIODS  = 8'h0C;

	// Counter control fields
	localparam int CTRL_WIDTH   = 5;
	localparam int CTRL_RISING  = 3;
	localparam int CTRL_GATE_EN = 4;

	// Interrupt status bit positions
	localparam int IRQ_BITS     = 7;
	localparam int IRQ_PATTERN  = 0;
	localparam int IRQ_COS      = 1;
	localparam int IRQ_EDGE     = 2;
	localparam int IRQ_MATCH0   = 3;
	localparam int IRQ_OVF0     = 5;

	// Values after reset
	localparam logic [7:0]  OUTPUT_RESET = 8'h00;
	localparam logic [15:0] MASK_RESET   = 16'h0000;
	localparam logic [4:0]  CTRL_RESET   = 5'h00;
	localparam logic [15:0] PERIOD_RESET = 16'h0001;

	typedef enum logic [2:0] {
		MODE_OFF, MODE_EVENT, MODE_FREQ, MODE_WIDTH, MODE_SINGLE, MODE_TRAIN
	} idci_mode_type;

	typedef enum logic [1:0] {PULSE_IDLE, PULSE_HIGH, PULSE_LOW} idci_pulse_type;

endpackage

`default_nettype wire

/* File: core/idci_core.sv */
// Isolated digital I/O core: 16 inputs, 8 outputs, two counters, interrupts.
// Assumes inputs synchronous to clock apart from the field lines, which are
// synchronised here; systemReset is a one-cycle host reset request.
//
// The plain strobed port and the address map were left to the implementer.
`default_nettype none

// Notes on behaviour
// - Sixteen inputs readable, eight outputs drivable
// - Two counters: event, frequency, pulse width
// - Counter match raises interrupt when enabled
// - Counting continues past match, wraps on overflow
// - Per counter rising or falling edge select
// - Counters generate single pulse or pulse train
// - Masked input pattern match raises interrupt
// - Any monitored input toggle raises interrupt
// - Edge interrupt with selectable polarity
// - Outputs and configuration can survive system reset
// - Board switch readable as card identifier
// - Counter events can interrupt the host
// - Option selects defaults or keep on reset
// - Counter inputs on lines 0,2 and 4,6
module idci_core #(
	parameter int CTR_WIDTH          = 16,
	parameter int FREQ_WINDOW_CYCLES = idci_pkg::FREQ_WINDOW_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        systemReset,
	input  wire logic [7:0]  address,
	input  wire logic [31:0] writeData,
	input  wire logic        writeStrobe,
	input  wire logic        readStrobe,
	output logic      [31:0] readData,
	input  wire logic [15:0] isoInputLine,
	output logic      [7:0]  isoOutputLine,
	output logic      [1:0]  counterPulseOut,
	input  wire logic        resetRetentionSelect,
	input  wire logic [3:0]  cardIdentifierSwitch,
	output logic             irq
);

	initial begin
		if (CTR_WIDTH < 16 || CTR_WIDTH > 32)
			$error("CTR_WIDTH must lie between 16 and 32");
		if (FREQ_WINDOW_CYCLES < 2)
			$error("FREQ_WINDOW_CYCLES must be at least 2");
	end

	localparam logic [31:0] WINDOW_LAST = 32'(FREQ_WINDOW_CYCLES - 1);

	function automatic logic [7:0] ctrAddr(input int ch, input logic [7:0] ofs);
		ctrAddr = 8'(idci_pkg::OFS_CTR_BASE + 8'(ch) * idci_pkg::CTR_STRIDE + ofs);
	endfunction

	// Input synchronisers
	logic [15:0] syncFirst, syncSecond, syncPrev;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			syncFirst  <= idci_pkg::MASK_RESET;
			syncSecond <= idci_pkg::MASK_RESET;
			syncPrev   <= idci_pkg::MASK_RESET;
		end else begin
			syncFirst  <= isoInputLine;
			syncSecond <= syncFirst;
			syncPrev   <= syncSecond;
		end
	end

	// Loading defaults on a host reset unless retention is strapped
	logic loadDefaults;
	assign loadDefaults = systemReset && !resetRetentionSelect;

	// Counters
	logic [4:0]           ctrl [2];
	logic [CTR_WIDTH-1:0] matchVal [2];
	logic [CTR_WIDTH-1:0] cnt [2];
	logic [CTR_WIDTH-1:0] result [2];
	logic [15:0]          highLen [2];
	logic [15:0]          lowLen [2];
	logic [31:0]          window [2];
	idci_pkg::idci_pulse_type pulse [2];
	logic [1:0]           pulseOut;
	logic [4:0]           next_ctrl [2];
	logic [CTR_WIDTH-1:0] next_matchVal [2];
	logic [CTR_WIDTH-1:0] next_cnt [2];
	logic [CTR_WIDTH-1:0] next_result [2];
	logic [15:0]          next_highLen [2];
	logic [15:0]          next_lowLen [2];
	logic [31:0]          next_window [2];
	idci_pkg::idci_pulse_type next_pulse [2];
	logic [1:0]           next_pulseOut;
	logic [1:0]           ctrMatchEvent, ctrOvfEvent;

	always_comb begin
		int countLine, gateLine;
		logic rising, edgeSeen, gateOk, active, wasActive, doInc;
		logic [CTR_WIDTH-1:0] incVal;
		countLine = 0;
		gateLine = 0;
		rising = 1'b0;
		edgeSeen = 1'b0;
		gateOk = 1'b0;
		active = 1'b0;
		wasActive = 1'b0;
		doInc = 1'b0;
		incVal = '0;
		ctrMatchEvent = 2'b00;
		ctrOvfEvent = 2'b00;
		next_pulseOut = 2'b00;
		for (int c = 0; c < idci_pkg::NUM_CTR; c++) begin
			next_ctrl[c] = ctrl[c];
			next_matchVal[c] = matchVal[c];
			next_cnt[c] = cnt[c];
			next_result[c] = result[c];
			next_highLen[c] = highLen[c];
			next_lowLen[c] = lowLen[c];
			next_window[c] = window[c];
			next_pulse[c] = pulse[c];
			countLine = (c == 0) ? idci_pkg::CTR0_COUNT_LINE
				: idci_pkg::CTR1_COUNT_LINE;
			gateLine = (c == 0) ? idci_pkg::CTR0_GATE_LINE
				: idci_pkg::CTR1_GATE_LINE;
			rising = ctrl[c][idci_pkg::CTRL_RISING];
			edgeSeen = rising
				? (syncSecond[countLine] && !syncPrev[countLine])
				: (!syncSecond[countLine] && syncPrev[countLine]);
			gateOk = !ctrl[c][idci_pkg::CTRL_GATE_EN] || syncSecond[gateLine];
			active = syncSecond[countLine] == rising;
			wasActive = syncPrev[countLine] == rising;
			doInc = 1'b0;
			incVal = CTR_WIDTH'(cnt[c] + 1'b1);
			case (idci_pkg::idci_mode_type'(ctrl[c][2:0]))
				idci_pkg::MODE_EVENT: begin
					doInc = edgeSeen && gateOk;
				end
				idci_pkg::MODE_FREQ: begin
					if (gateOk) begin
						doInc = edgeSeen;
						next_window[c] = window[c] + 32'h0000_0001;
						if (window[c] >= WINDOW_LAST) begin
							next_result[c] = edgeSeen ? incVal : cnt[c];
							next_window[c] = 32'h0000_0000;
						end
					end
				end
				idci_pkg::MODE_WIDTH: begin
					if (active && gateOk) begin
						doInc = 1'b1;
					end else if (wasActive && !active) begin
						next_result[c] = cnt[c];
						next_cnt[c] = '0;
					end
				end
				idci_pkg::MODE_SINGLE, idci_pkg::MODE_TRAIN: begin
					case (pulse[c])
						idci_pkg::PULSE_HIGH: begin
							next_cnt[c] = incVal;
							if (incVal >= CTR_WIDTH'(highLen[c])) begin
								next_cnt[c] = '0;
								next_pulse[c] = (ctrl[c][2:0] == idci_pkg::MODE_TRAIN)
									? idci_pkg::PULSE_LOW : idci_pkg::PULSE_IDLE;
							end
						end
						idci_pkg::PULSE_LOW: begin
							next_cnt[c] = incVal;
							if (incVal >= CTR_WIDTH'(lowLen[c])) begin
								next_cnt[c] = '0;
								next_pulse[c] = idci_pkg::PULSE_HIGH;
							end
						end
						default: begin
							next_pulse[c] = idci_pkg::PULSE_IDLE;
						end
					endcase
				end
				default: begin
					next_pulse[c] = idci_pkg::PULSE_IDLE;
				end
			endcase
			if (doInc) begin
				next_cnt[c] = incVal;
				if (incVal == matchVal[c])
					ctrMatchEvent[c] = 1'b1;
				if (cnt[c] == {CTR_WIDTH{1'b1}})
					ctrOvfEvent[c] = 1'b1;
				if (idci_pkg::idci_mode_type'(ctrl[c][2:0]) == idci_pkg::MODE_FREQ
					&& window[c] >= WINDOW_LAST && gateOk)
					next_cnt[c] = '0;
			end else if (idci_pkg::idci_mode_type'(ctrl[c][2:0])
				== idci_pkg::MODE_FREQ && window[c] >= WINDOW_LAST && gateOk) begin
				next_cnt[c] = '0;
			end
			if (writeStrobe) begin
				if (address == ctrAddr(c, idci_pkg::CTR_CTRL)) begin
					next_ctrl[c] = writeData[4:0];
					next_cnt[c] = '0;
					next_result[c] = '0;
					next_window[c] = 32'h0000_0000;
					next_pulse[c] = (writeData[2:0] == idci_pkg::MODE_SINGLE
						|| writeData[2:0] == idci_pkg::MODE_TRAIN)
						? idci_pkg::PULSE_HIGH : idci_pkg::PULSE_IDLE;
				end else if (address == ctrAddr(c, idci_pkg::CTR_MATCH)) begin
					next_matchVal[c] = writeData[CTR_WIDTH-1:0];
				end else if (address == ctrAddr(c, idci_pkg::CTR_PERIODS)) begin
					next_highLen[c] = writeData[31:16];
					next_lowLen[c] = writeData[15:0];
				end
			end
			if (systemReset) begin
				next_cnt[c] = '0;
				next_result[c] = '0;
				next_window[c] = 32'h0000_0000;
				next_pulse[c] = idci_pkg::PULSE_IDLE;
				if (loadDefaults) begin
					next_ctrl[c] = idci_pkg::CTRL_RESET;
					next_matchVal[c] = '0;
					next_highLen[c] = idci_pkg::PERIOD_RESET;
					next_lowLen[c] = idci_pkg::PERIOD_RESET;
				end
			end
			next_pulseOut[c] = next_pulse[c] == idci_pkg::PULSE_HIGH;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int c = 0; c < idci_pkg::NUM_CTR; c++) begin
				ctrl[c]     <= idci_pkg::CTRL_RESET;
				matchVal[c] <= '0;
				cnt[c]      <= '0;
				result[c]   <= '0;
				highLen[c]  <= idci_pkg::PERIOD_RESET;
				lowLen[c]   <= idci_pkg::PERIOD_RESET;
				window[c]   <= 32'h0000_0000;
				pulse[c]    <= idci_pkg::PULSE_IDLE;
			end
			pulseOut <= 2'b00;
		end else begin
			ctrl     <= next_ctrl;
			matchVal <= next_matchVal;
			cnt      <= next_cnt;
			result   <= next_result;
			highLen  <= next_highLen;
			lowLen   <= next_lowLen;
			window   <= next_window;
			pulse    <= next_pulse;
			pulseOut <= next_pulseOut;
		end
	end

	assign counterPulseOut = pulseOut;

	// Host registers and interrupts
	logic [7:0]  outLevels, next_outLevels;
	logic [15:0] patMask, patVal, cosMask, edgeEn, edgePol;
	logic [15:0] next_patMask, next_patVal, next_cosMask;
	logic [15:0] next_edgeEn, next_edgePol;
	logic [6:0]  irqStat, irqMask, next_irqStat, next_irqMask;
	logic        patPrev, next_patPrev;
	logic [31:0] next_readData;

	always_comb begin
		logic patNow;
		logic [6:0] events;
		int c;
		c = 0;
		patNow = (patMask != idci_pkg::MASK_RESET)
			&& (((syncSecond ^ patVal) & patMask) == 16'h0000);
		events = 7'h00;
		events[idci_pkg::IRQ_PATTERN] = patNow && !patPrev;
		events[idci_pkg::IRQ_COS] = |((syncSecond ^ syncPrev) & cosMask);
		events[idci_pkg::IRQ_EDGE] = |(edgeEn & ((edgePol & syncSecond & ~syncPrev)
			| (~edgePol & ~syncSecond & syncPrev)));
		events[idci_pkg::IRQ_MATCH0 +: 2] = ctrMatchEvent;
		events[idci_pkg::IRQ_OVF0 +: 2] = ctrOvfEvent;
		next_outLevels = outLevels;
		next_patMask = patMask;
		next_patVal = patVal;
		next_cosMask = cosMask;
		next_edgeEn = edgeEn;
		next_edgePol = edgePol;
		next_irqMask = irqMask;
		next_irqStat = irqStat;
		next_patPrev = patNow;
		next_readData = 32'h0000_0000;
		if (writeStrobe) begin
			if (address == idci_pkg::OFS_OUTPUT)
				next_outLevels = writeData[7:0];
			else if (address == idci_pkg::OFS_PAT_MASK)
				next_patMask = writeData[15:0];
			else if (address == idci_pkg::OFS_PAT_VAL)
				next_patVal = writeData[15:0];
			else if (address == idci_pkg::OFS_COS_MASK)
				next_cosMask = writeData[15:0];
			else if (address == idci_pkg::OFS_EDGE_EN)
				next_edgeEn = writeData[15:0];
			else if (address == idci_pkg::OFS_EDGE_POL)
				next_edgePol = writeData[15:0];
			else if (address == idci_pkg::OFS_IRQ_STAT)
				next_irqStat = irqStat & ~writeData[6:0];
			else if (address == idci_pkg::OFS_IRQ_MASK)
				next_irqMask = writeData[6:0];
		end
		next_irqStat = next_irqStat | events;
		if (loadDefaults) begin
			next_outLevels = idci_pkg::OUTPUT_RESET;
			next_patMask = idci_pkg::MASK_RESET;
			next_patVal = idci_pkg::MASK_RESET;
			next_cosMask = idci_pkg::MASK_RESET;
			next_edgeEn = idci_pkg::MASK_RESET;
			next_edgePol = idci_pkg::MASK_RESET;
			next_irqMask = 7'h00;
		end
		if (systemReset)
			next_irqStat = 7'h00;
		if (readStrobe) begin
			if (address == idci_pkg::OFS_INPUT)
				next_readData = {16'h0000, syncSecond};
			else if (address == idci_pkg::OFS_OUTPUT)
				next_readData = {24'h00_0000, outLevels};
			else if (address == idci_pkg::OFS_BOARD_ID)
				next_readData = {28'h000_0000, ~cardIdentifierSwitch};
			else if (address == idci_pkg::OFS_PAT_MASK)
				next_readData = {16'h0000, patMask};
			else if (address == idci_pkg::OFS_PAT_VAL)
				next_readData = {16'h0000, patVal};
			else if (address == idci_pkg::OFS_COS_MASK)
				next_readData = {16'h0000, cosMask};
			else if (address == idci_pkg::OFS_EDGE_EN)
				next_readData = {16'h0000, edgeEn};
			else if (address == idci_pkg::OFS_EDGE_POL)
				next_readData = {16'h0000, edgePol};
			else if (address == idci_pkg::OFS_IRQ_STAT)
				next_readData = {25'h000_0000, irqStat};
			else if (address == idci_pkg::OFS_IRQ_MASK)
				next_readData = {25'h000_0000, irqMask};
			else begin
				for (c = 0; c < idci_pkg::NUM_CTR; c++) begin
					if (address == ctrAddr(c, idci_pkg::CTR_CTRL))
						next_readData = {27'h000_0000, ctrl[c]};
					else if (address == ctrAddr(c, idci_pkg::CTR_MATCH))
						next_readData = 32'(matchVal[c]);
					else if (address == ctrAddr(c, idci_pkg::CTR_VALUE))
						next_readData = (ctrl[c][2:0] == idci_pkg::MODE_EVENT)
							? 32'(cnt[c]) : 32'(result[c]);
					else if (address == ctrAddr(c, idci_pkg::CTR_PERIODS))
						next_readData = {highLen[c], lowLen[c]};
				end
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			outLevels <= idci_pkg::OUTPUT_RESET;
			patMask   <= idci_pkg::MASK_RESET;
			patVal    <= idci_pkg::MASK_RESET;
			cosMask   <= idci_pkg::MASK_RESET;
			edgeEn    <= idci_pkg::MASK_RESET;
			edgePol   <= idci_pkg::MASK_RESET;
			irqStat   <= 7'h00;
			irqMask   <= 7'h00;
			patPrev   <= 1'b0;
			readData  <= 32'h0000_0000;
		end else begin
			outLevels <= next_outLevels;
			patMask   <= next_patMask;
			patVal    <= next_patVal;
			cosMask   <= next_cosMask;
			edgeEn    <= next_edgeEn;
			edgePol   <= next_edgePol;
			irqStat   <= next_irqStat;
			irqMask   <= next_irqMask;
			patPrev   <= next_patPrev;
			readData  <= next_readData;
		end
	end

	assign isoOutputLine = outLevels;
	assign irq = |(irqStat & irqMask);

endmodule

`default_nettype wire

/* File: tb/idci_monitor.sv */
// Port-level checker for the isolated DIO core.
// Assumes it is bound to idci_core: one clock, async active-low reset.
`default_nettype none

module idci_monitor (
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        systemReset,
	input wire logic [7:0]  address,
	input wire logic [31:0] writeData,
	input wire logic        writeStrobe,
	input wire logic        readStrobe,
	input wire logic [31:0] readData,
	input wire logic [7:0]  isoOutputLine,
	input wire logic [1:0]  counterPulseOut,
	input wire logic        resetRetentionSelect,
	input wire logic [3:0]  cardIdentifierSwitch,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	logic outWrite;
	assign outWrite = writeStrobe && address == idci_pkg::OFS_OUTPUT;

	read_idle_a: assert property (!readStrobe |=> readData == 32'h0)
		else $error("read data not zero outside a read");
	board_id_a: assert property (readStrobe && address == 8'h08
		|=> readData == {28'h0, ~$past(cardIdentifierSwitch)})
		else $error("card identifier read wrong");
	unmapped_read_a: assert property (readStrobe && address == 8'hFC
		|=> readData == 32'h0)
		else $error("unmapped read not zero");
	out_write_a: assert property (outWrite && !systemReset
		|=> isoOutputLine == $past(writeData[7:0]))
		else $error("output register write lost");
	out_hold_a: assert property (!outWrite && !systemReset
		|=> $stable(isoOutputLine))
		else $error("outputs changed without a write");
	keep_outputs_a: assert property (systemReset && resetRetentionSelect
		&& !writeStrobe |=> $stable(isoOutputLine))
		else $error("outputs lost on retained reset");
	default_outputs_a: assert property (systemReset
		&& !resetRetentionSelect && !writeStrobe |=> isoOutputLine == 8'h00)
		else $error("outputs kept on default reset");
	mask_clear_a: assert property (writeStrobe && address == 8'h24
		&& writeData[6:0] == 7'h00 && !systemReset |=> !irq)
		else $error("interrupt high with all sources masked");
	pulse_start_a: assert property (writeStrobe && address == 8'h30
		&& writeData[2:0] == 3'd4 && !systemReset |=> counterPulseOut[0])
		else $error("single pulse did not start");

	cover property (irq);
	cover property (systemReset && resetRetentionSelect);
	cover property ($fell(counterPulseOut[0]));
endmodule

`default_nettype wire

/* File: tb/idci_field_model.sv */
// Field side of the card: switches on the inputs, a load on the outputs.
// Assumes the bench calls its tasks; lines change just after clock edges.
`default_nettype none

module idci_field_model (
	input  wire logic        clock,
	input  wire logic [7:0]  loadLine,
	output logic      [15:0] fieldLine
);
	timeunit 1ns;
	timeprecision 1ns;

	initial fieldLine = 16'h0000;

	task automatic setLines(input logic [15:0] v);
		@(posedge clock);
		fieldLine <= v;
	endtask

	// Pulses on the counter 0 count line, two cycles high and three low
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clock);
			fieldLine[0] <= 1'b1;
			repeat (2) @(posedge clock);
			fieldLine[0] <= 1'b0;
			repeat (2) @(posedge clock);
		end
	endtask
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the isolated DIO core.
// Assumes idci_core, idci_monitor and the field model are compiled first.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock;
	logic        reset_n;
	logic        systemReset;
	logic [7:0]  address;
	logic [31:0] writeData;
	logic        writeStrobe;
	logic        readStrobe;
	logic [31:0] readData;
	logic [15:0] isoInputLine;
	logic [7:0]  isoOutputLine;
	logic [1:0]  counterPulseOut;
	logic        retain;
	logic [3:0]  idSwitch;
	logic        irq;
	logic        pend;
	logic [31:0] rnd;
	logic [31:0] expQ[$];
	int          n_errors;
	int          tests_run;
	int          cyc;
	int          highs;
	int          trains;

	idci_core #(.CTR_WIDTH(16), .FREQ_WINDOW_CYCLES(20)) DUT (
		.clock, .reset_n, .systemReset, .address, .writeData, .writeStrobe,
		.readStrobe, .readData, .isoInputLine, .isoOutputLine,
		.counterPulseOut, .resetRetentionSelect(retain),
		.cardIdentifierSwitch(idSwitch), .irq);

	idci_field_model field (.clock, .loadLine(isoOutputLine),
		.fieldLine(isoInputLine));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		writeStrobe <= 1'b1;
		readStrobe  <= 1'b0;
		address     <= a;
		writeData   <= d;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		readStrobe  <= 1'b1;
		writeStrobe <= 1'b0;
		address     <= a;
		expQ.push_back(e);
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clock);
			writeStrobe <= 1'b0;
			readStrobe  <= 1'b0;
		end
	endtask

	task automatic lines(input logic [15:0] v);
		idle(1);
		field.setLines(v);
		idle(6);
	endtask

	task automatic sysReset(input logic keep);
		idle(1);
		retain      <= keep;
		systemReset <= 1'b1;
		idle(1);
		systemReset <= 1'b0;
	endtask

	// Read results land one cycle after the read edge
	always @(posedge clock) begin
		if (pend && expQ.size() > 0)
			check(readData, expQ.pop_front());
		pend <= readStrobe;
	end

	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			results();
		end
	end

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	initial begin
		{reset_n, systemReset, writeStrobe, readStrobe, retain} = '0;
		address = 8'h00;
		writeData = 32'h0000_0000;
		rnd = $urandom(32'h58ac_f755);
		idSwitch = 4'($urandom);
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		rnd = $urandom;
		rd(8'h08, {28'h0, ~idSwitch});
		rd(8'hFC, 32'h0);
		wr(8'h04, rnd);
		rd(8'h04, {24'h0, rnd[7:0]});
		idle(1);
		check({24'h0, field.loadLine}, {24'h0, rnd[7:0]});
		wr(8'h34, 32'h3);
		wr(8'h24, 32'h8);
		wr(8'h30, 32'h9);
		idle(2);
		field.pulse(5);
		idle(6);
		rd(8'h38, 32'h5);
		rd(8'h20, 32'h8);
		idle(2);
		check({31'h0, irq}, 32'h1);
		wr(8'h20, 32'h8);
		idle(2);
		check({31'h0, irq}, 32'h0);
		wr(8'h30, 32'h1);
		lines(16'h0001);
		rd(8'h38, 32'h0);
		lines(16'h0000);
		rd(8'h38, 32'h1);
		wr(8'h30, 32'h0);
		lines(16'h6042);
		rd(8'h00, 32'h6042);
		wr(8'h24, 32'h7);
		wr(8'h10, 32'h0100);
		wr(8'h0C, 32'h0300);
		wr(8'h14, 32'h0800);
		wr(8'h18, 32'h1000);
		wr(8'h1C, 32'h0);
		lines(16'h6142);
		rd(8'h20, 32'h1);
		wr(8'h20, 32'h1);
		lines(16'h6942);
		rd(8'h20, 32'h2);
		wr(8'h20, 32'h2);
		lines(16'h7942);
		rd(8'h20, 32'h0);
		lines(16'h6942);
		rd(8'h20, 32'h4);
		rnd = $urandom;
		wr(8'h04, rnd);
		sysReset(1'b1);
		rd(8'h04, {24'h0, rnd[7:0]});
		rd(8'h14, 32'h0800);
		rd(8'h20, 32'h0);
		sysReset(1'b0);
		rd(8'h04, 32'h0);
		rd(8'h14, 32'h0);
		wr(8'h40, 32'hB);
		lines(16'h6952);
		lines(16'h6942);
		rd(8'h48, 32'h8);
		wr(8'h30, 32'hA);
		fork
			field.pulse(12);
			begin
				idle(40);
				rd(8'h38, 32'h4);
				idle(1);
			end
		join
		wr(8'h30, 32'h19);
		idle(1);
		field.pulse(2);
		lines(16'h6946);
		field.pulse(2);
		idle(6);
		rd(8'h38, 32'h2);
		wr(8'h3C, {16'd5, 16'd1});
		wr(8'h4C, {16'd2, 16'd3});
		wr(8'h40, 32'h5);
		wr(8'h30, 32'h4);
		highs = 0;
		trains = 0;
		repeat (25) begin
			idle(1);
			@(negedge clock);
			if (counterPulseOut[0] === 1'b1)
				highs++;
			if (counterPulseOut[1] === 1'b1)
				trains++;
		end
		check(32'(highs), 32'd5);
		check(32'(trains), 32'd10);
		wr(8'h24, 32'h0);
		idle(4);
		results();
	end
endmodule

bind idci_core idci_monitor mon (
	.clock, .reset_n, .systemReset, .address, .writeData, .writeStrobe,
	.readStrobe, .readData, .isoOutputLine, .counterPulseOut,
	.resetRetentionSelect, .cardIdentifierSwitch, .irq);

`default_nettype wire
